/* File: src/sahi_pkg.sv */
package sahi_pkg;
  // clk acts as conversion clock; conversion and start delays in ns
  localparam int CLK_PERIOD_NS = 5;
  localparam int START_DELAY_NS = 95;
  localparam int CONV_TIME_NS = 740;
  localparam int START_DELAY_CYC = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TIME_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_W = 12;
  localparam logic [DATA_W-1:0] RESULT_RST = 12'h000;
  localparam logic CHAN_ONE = 1'b0;
  localparam logic CHAN_TWO = 1'b1;
  localparam logic STYLE_INTERRUPT = 1'b0;
  typedef enum {SAHI_IDLE, SAHI_START, SAHI_CONV} sahi_state_t;
endpackage

/* File: src/sahi_bus_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface sahi_bus_if #(parameter int W = 12);
  logic [W-1:0] result;
  logic cs_n;
  logic rd_n;
  logic oe;
  logic eoc_n;
  logic [W-1:0] bus_out;
  logic bus_oe;
  modport core (output result, output cs_n, output rd_n, output oe, output eoc_n, input bus_out, input bus_oe);
  modport drv (input result, input cs_n, input rd_n, input oe, input eoc_n, output bus_out, output bus_oe);
endinterface
`default_nettype wire

/* File: src/sahi_out_drv.sv */
`timescale 1ns/10ps
`default_nettype none
module sahi_out_drv #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  sahi_bus_if.drv bus
);
  logic [W-1:0] bus_out_r;
  logic [W-1:0] bus_out_nxt;
  logic bus_oe_r;
  logic bus_oe_nxt;

  always_comb
  begin
    bus_oe_nxt = bus.oe && !bus.cs_n && !bus.rd_n;
    bus_out_nxt = bus.result;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_oe_r <= 1'b0;
      bus_out_r <= '0;
    end
    else
    begin
      bus_oe_r <= bus_oe_nxt;
      bus_out_r <= bus_out_nxt;
    end
  end

  assign bus.bus_out = bus_out_r;
  assign bus.bus_oe = bus_oe_r;
endmodule // sahi_out_drv
`default_nettype wire

/* File: src/sahi_top.sv */
// Behaviour
// - channel pick sampled when end-of-conversion falls
// - strobe fall with select low starts conversion
// - completion raises eoc, latches, drops attention in interrupt style
// - high-speed style leaves attention high at completion
// - low pick routes channel one, high two
// - read with select low raises attention
// - bus driven only when enabled and selected
// - eoc low throughout a conversion
`timescale 1ns/10ps
`default_nettype none
module sahi_top #(
  parameter int DATA_W = sahi_pkg::DATA_W,
  parameter int START_CYC = sahi_pkg::START_DELAY_CYC,
  parameter int CONV_CYC = sahi_pkg::CONV_TIME_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_strobe,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic oe,
  input wire logic channel_pick,
  input wire logic interface_style_strap,
  input wire logic [DATA_W-1:0] conv_value,
  output logic eoc_n,
  output logic attn_n,
  output logic selected_channel_out,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe
);
  // refuse settings that the counter and the data path cannot serve
  if (DATA_W < 1)
  begin : g_bad_width
    $error("sahi_top: data width must be at least one bit");
  end
  if (START_CYC < 1 || CONV_CYC < 1)
  begin : g_bad_timing
    $error("sahi_top: phase counts must be at least one cycle");
  end

  // one counter serves both phases, so it is sized for their sum
  localparam int CW = $clog2(START_CYC + CONV_CYC + 1);

  sahi_pkg::sahi_state_t state_r;
  sahi_pkg::sahi_state_t state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic strobe_d_r;
  logic strobe_d_nxt;
  logic eoc_n_r;
  logic eoc_n_nxt;
  logic attn_n_r;
  logic attn_n_nxt;
  logic chan_r;
  logic chan_nxt;
  logic [DATA_W-1:0] result_r;
  logic [DATA_W-1:0] result_nxt;
  logic strobe_fall;
  logic take;
  logic conv_begin;
  logic conv_done;
  logic read_act;

  sahi_bus_if #(.W(DATA_W)) bus ();

  assign bus.result = result_r;
  assign bus.cs_n = cs_n;
  assign bus.rd_n = rd_n;
  assign bus.oe = oe;
  assign bus.eoc_n = eoc_n_r;

  sahi_out_drv #(.W(DATA_W)) u_drv (
    .clk(clk),
    .rst_n(rst_n),
    .bus(bus)
  );

  // events shared by the three groups of state below
  always_comb
  begin
    strobe_fall = strobe_d_r && !sample_strobe;
    take = strobe_fall && !cs_n && (state_r == sahi_pkg::SAHI_IDLE);
    conv_begin = (state_r == sahi_pkg::SAHI_START) && (cnt_r == '0);
    conv_done = (state_r == sahi_pkg::SAHI_CONV) && (cnt_r == '0);
    read_act = !rd_n && !cs_n;
  end

  // sequencer: strobe falls while busy are dropped, not queued
  always_comb
  begin
    strobe_d_nxt = sample_strobe;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      sahi_pkg::SAHI_IDLE:
      begin
        if (take)
        begin
          state_nxt = sahi_pkg::SAHI_START;
          cnt_nxt = CW'(START_CYC - 1);
        end
      end
      sahi_pkg::SAHI_START:
      begin
        if (conv_begin)
        begin
          state_nxt = sahi_pkg::SAHI_CONV;
          cnt_nxt = CW'(CONV_CYC - 1);
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      sahi_pkg::SAHI_CONV:
      begin
        if (conv_done)
          state_nxt = sahi_pkg::SAHI_IDLE;
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      default:
        state_nxt = sahi_pkg::SAHI_IDLE;
    endcase
  end

  // strobe history resets to its idle level so no false fall follows reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= sahi_pkg::SAHI_IDLE;
      cnt_r <= '0;
      strobe_d_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      strobe_d_r <= strobe_d_nxt;
    end
  end

  // status flags
  always_comb
  begin
    eoc_n_nxt = eoc_n_r;
    attn_n_nxt = attn_n_r;
    if (conv_begin)
      eoc_n_nxt = 1'b0;
    else if (conv_done)
      eoc_n_nxt = 1'b1;
    // completion wins over a concurrent read so the event is not lost
    if (conv_done && (interface_style_strap == sahi_pkg::STYLE_INTERRUPT))
      attn_n_nxt = 1'b0;
    else if (read_act)
      attn_n_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eoc_n_r <= 1'b1;
      attn_n_r <= 1'b1;
    end
    else
    begin
      eoc_n_r <= eoc_n_nxt;
      attn_n_r <= attn_n_nxt;
    end
  end

  // channel choice and result latch
  always_comb
  begin
    chan_nxt = chan_r;
    result_nxt = result_r;
    if (conv_begin)
      chan_nxt = channel_pick ? sahi_pkg::CHAN_TWO : sahi_pkg::CHAN_ONE;
    if (conv_done)
      result_nxt = conv_value;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_r <= sahi_pkg::CHAN_ONE;
      result_r <= sahi_pkg::RESULT_RST;
    end
    else
    begin
      chan_r <= chan_nxt;
      result_r <= result_nxt;
    end
  end

  assign eoc_n = eoc_n_r;
  assign attn_n = attn_n_r;
  assign selected_channel_out = chan_r;
  assign data_out = bus.bus_out;
  assign data_oe = bus.bus_oe;
endmodule // sahi_top
`default_nettype wire

/* File: verif/sahi_host.sv */
`timescale 1ns/10ps
`default_nettype none
module sahi_host (
  input wire logic clk,
  input wire logic go,
  output logic sample_strobe = 1'h1
);
  always @(posedge clk) sample_strobe <= !go;
endmodule // sahi_host
`default_nettype wire

/* File: verif/sahi_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module sahi_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic oe,
  input wire logic interface_style_strap,
  input wire logic eoc_n,
  input wire logic attn_n,
  input wire logic [11:0] data_out,
  input wire logic data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_eoc_len: assert property ($fell(eoc_n) |-> !eoc_n [*4] ##1 eoc_n) else $error("eoc");
  chk_attn_low: assert property ($rose(eoc_n) && !interface_style_strap |-> !attn_n) else $error("attn");
  chk_attn_off: assert property ($rose(eoc_n) && interface_style_strap |-> attn_n) else $error("attn");
  chk_attn_sync: assert property ($fell(attn_n) |-> $rose(eoc_n)) else $error("attn");
  chk_attn_keep: assert property (!attn_n && (rd_n || cs_n) |=> !attn_n) else $error("attn");
  chk_read_clr: assert property (!rd_n && !cs_n ##1 !$rose(eoc_n) |-> attn_n) else $error("read");
  chk_bus_en: assert property (data_oe |-> $past(oe) && !$past(cs_n) && !$past(rd_n)) else $error("oe");
  chk_data_hold: assert property ($changed(data_out) |-> $past(eoc_n) && !$past(eoc_n, 2)) else $error("data");
endmodule // sahi_chk
bind sahi_top sahi_chk u_sahi_chk (.*);
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'h0, rst_n = 1'h0, cs_n = 1'h0, rd_n = 1'h1, oe = 1'h1, go = 1'h0, channel_pick = 1'h0;
  logic interface_style_strap = 1'h0, sample_strobe, eoc_n, attn_n, selected_channel_out, data_oe;
  logic [11:0] conv_value = 12'h000, data_out;
  int bad_count, n_compared, cyc;
  sahi_top #(.START_CYC(2), .CONV_CYC(4)) u_sahi_top (.*);
  sahi_host u_sahi_host (.*);
  initial forever #2.5 clk = ~clk;
  task wrap_up(input int extra);
    bad_count += extra;
    $display("%0d %0d", bad_count, n_compared);
    if (!bad_count && n_compared)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
    if (++cyc == 500)
      wrap_up(1);
  task ck(input logic [11:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task t_conv(input logic p, s, input logic [11:0] v);
    channel_pick = p;
    interface_style_strap = s;
    conv_value = v;
    go = 1'h1;
    @(negedge clk);
    go = 1'h0;
    repeat (4) @(negedge clk);
    ck(eoc_n, 1'h0);
    repeat (5) @(negedge clk);
    ck(eoc_n, 1'h1);
    ck(attn_n, s);
    ck(data_out, v);
    ck(selected_channel_out, p);
    ck(data_oe, 1'h0);
    rd_n = 1'h0;
    @(negedge clk);
    ck(attn_n, 1'h1);
    ck(data_oe, 1'h1);
    rd_n = 1'h1;
  endtask
  task t_fast(input logic [11:0] v);
    interface_style_strap = 1'h1;
    conv_value = v;
    rd_n = 1'h0;
    go = 1'h1;
    @(negedge clk);
    go = 1'h0;
    repeat (9) @(negedge clk);
    ck(data_out, v);
    ck(data_oe, 1'h1);
    oe = 1'h0;
    @(negedge clk);
    ck(data_oe, 1'h0);
    oe = 1'h1;
    cs_n = 1'h1;
    go = 1'h1;
    @(negedge clk);
    go = 1'h0;
    repeat (4) @(negedge clk);
    ck(eoc_n, 1'h1);
    ck(data_oe, 1'h0);
    ck(data_out, v);
    cs_n = 1'h0;
    rd_n = 1'h1;
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    t_conv(1'h0, 1'h0, 12'h5a3);
    t_conv(1'h1, 1'h1, 12'ha5c);
    t_fast(12'h3c6);
    wrap_up(0);
  end
endmodule // tb
`default_nettype wire
